/* File: ascs_params.svh */
// Purpose: Register map, field positions, reset values and timing counts
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Only low byte of each register is used except the 16-bit divisor, upper bits read as zero
`ifndef ASCS_PARAMS_SVH
`define ASCS_PARAMS_SVH

`define ASCS_ADDR_LFC 8'h00
`define ASCS_ADDR_TRC 8'h04
`define ASCS_ADDR_NEC 8'h08
`define ASCS_ADDR_FLG 8'h0C
`define ASCS_ADDR_DAT 8'h10
`define ASCS_ADDR_BAUD 8'h14

`define ASCS_LFC_MODULE_ON 6
`define ASCS_LFC_NINE 4
`define ASCS_LFC_WAKE 3
`define ASCS_LFC_QAS 2
`define ASCS_LFC_PARITY 1
`define ASCS_LFC_ODD 0
`define ASCS_LFC_MASK 8'h5F
`define ASCS_LFC_RST 8'h00

`define ASCS_TRC_RST 8'h00
`define ASCS_TRC_TX_ON 3
`define ASCS_TRC_RX_ON 2
`define ASCS_NEC_RX_NINTH 7
`define ASCS_NEC_TX_NINTH 6
`define ASCS_NEC_RST 4'h0

`define ASCS_BAUD_RST 16'h0035
`define ASCS_PHASE_LAST 4'hF
`define ASCS_PHASE_S1 4'h7
`define ASCS_PHASE_S2 4'h8
`define ASCS_PHASE_S3 4'h9
`define ASCS_LEN8 4'hA
`define ASCS_LEN9 4'hB

`endif

/* File: ascs_pkg.sv */
// Purpose: Types shared by the serial control and status block
// Assumes: One-hot state encoding
// Notes: None
package ascs_pkg;
  typedef enum logic [3:0] {
    ASCS_TX_IDLE = 4'b0001,
    ASCS_TX_PRE = 4'b0010,
    ASCS_TX_BRK = 4'b0100,
    ASCS_TX_DATA = 4'b1000
  } ascs_tx_t;
  typedef enum logic [2:0] {
    ASCS_RX_IDLE = 3'b001,
    ASCS_RX_START = 3'b010,
    ASCS_RX_DATA = 3'b100
  } ascs_rx_t;
endpackage

/* File: ascs_ctrl.sv */
// Purpose: Serial transceiver control and status registers with line engines
// Assumes: APB slave, zero wait states, rxd synchronous to clk
// Notes: 16x oversampled receiver, bit rate set by the divisor register
// What this block does
// - Idle ones counted after stop or start bit
// - Parity bit sits in frame MSB position
// - Parity select one is odd, zero even
// - Tx empty interrupts only when enabled
// - Tx done interrupts only when enabled
// - Rx full interrupts only when enabled
// - Idle flag interrupts only when enabled
// - Enabling transmitter sends preamble of ones
// - Disabling transmitter finishes frame, line idles high
// - Re-enable during frame queues an idle character
// - Receiver enable gates reception, flags untouched
// - Standby masks rx interrupts, wake clears it
// - Break toggle sends break plus one high bit
// - Break held sends breaks back to back
// - Break toggle before preamble replaces the preamble
// - Received ninth bit captured with data, no reset
// - Tx ninth bit forms frame bit eight
// - Error flags interrupt only when individually enabled
// - Tx empty sets on transfer, clears read-then-write
// - Reset sets empty, clears enables, standby, break
// - Wake select one address mark, zero idle
// - Tx done when empty and nothing sending
// - Module off sets empty, done unless break held with tx on, masks tx interrupts
`timescale 1ns/1ps
`include "ascs_params.svh"

module ascs_ctrl
  import ascs_pkg::*;
(
  input wire logic clk, // Module clock
  input wire logic rst, // Synchronous reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic rxd, // Serial receive line
  output logic txd, // Serial transmit line
  output logic tx_irq, // Transmitter interrupt request
  output logic rx_irq, // Receiver interrupt request
  output logic err_irq // Receiver error interrupt request
);

  function automatic logic ascs_xor(input logic [8:0] v, input logic nine);
    ascs_xor = nine ? ^v : ^v[7:0];
  endfunction

  logic [7:0] lfc_q, trc_q, tdata_q, rdata_q;
  logic [15:0] baud_q, div_q;
  logic tx_ninth_bit_q, rx_ninth_bit_q;
  logic [3:0] err_en_q;
  logic tx_buffer_empty_q, rx_buffer_full_q, idle_q, overrun_q;
  logic noise_err_q, framing_fault_q, parity_fault_q;
  logic [31:0] prdata_q;
  logic [5:0] rx_arm_q;
  logic tx_arm_q, pre_pend_q, brk_pend_q, idle_armed_q, txd_q;
  ascs_tx_t tx_st_q;
  ascs_rx_t rx_st_q;
  logic [11:0] tx_sh_q;
  logic [3:0] tx_cnt_q, tx_ph_q, rx_ph_q, rx_cnt_q, ones_q;
  logic [9:0] rx_sh_q;
  logic s1_q, s2_q, rx_noise_q;

  logic module_on, nine, wake, quiet_count_after_stop, parity_on, odd_parity_sel;
  logic tx_empty_irq_en, tx_done_irq_en, rx_full_irq_en, quiet_irq_en;
  logic tx_on, rx_on, rx_standby, break_send, tx_done;
  logic setup, wr, rd, tick, tx_bit_end, tx_load, rx_bit, rx_sample, noise_now;
  logic stop_now, accept, addr_wake, quiet_event, mapped;
  logic [3:0] len, nbits;
  logic [8:0] rx_msbv;
  logic [11:0] frame;
  logic [7:0] trc_wr;

  assign module_on = lfc_q[`ASCS_LFC_MODULE_ON];
  assign nine = lfc_q[`ASCS_LFC_NINE];
  assign wake = lfc_q[`ASCS_LFC_WAKE];
  assign quiet_count_after_stop = lfc_q[`ASCS_LFC_QAS];
  assign parity_on = lfc_q[`ASCS_LFC_PARITY];
  assign odd_parity_sel = lfc_q[`ASCS_LFC_ODD];
  assign {tx_empty_irq_en, tx_done_irq_en, rx_full_irq_en, quiet_irq_en} = trc_q[7:4];
  assign {tx_on, rx_on, rx_standby, break_send} = trc_q[3:0];
  assign len = nine ? `ASCS_LEN9 : `ASCS_LEN8;
  assign nbits = nine ? 4'h9 : 4'h8;

  // APB decode, zero wait states
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & mapped;
  assign rd = psel & penable & ~pwrite & mapped;
  assign pready = 1'b1;
  assign mapped = (paddr == `ASCS_ADDR_LFC) | (paddr == `ASCS_ADDR_TRC) |
                  (paddr == `ASCS_ADDR_NEC) | (paddr == `ASCS_ADDR_FLG) |
                  (paddr == `ASCS_ADDR_DAT) | (paddr == `ASCS_ADDR_BAUD);
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_q;

  // Read data captured in the setup cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_q <= 32'h00000000;
    end else if (setup & ~pwrite) begin
      unique case (paddr)
        `ASCS_ADDR_LFC: prdata_q <= {24'h000000, lfc_q};
        `ASCS_ADDR_TRC: prdata_q <= {24'h000000, trc_q};
        `ASCS_ADDR_NEC: prdata_q <= {24'h000000, rx_ninth_bit_q, tx_ninth_bit_q, 2'b00, err_en_q};
        `ASCS_ADDR_FLG: prdata_q <= {24'h000000, tx_buffer_empty_q, tx_done, rx_buffer_full_q,
                                     idle_q, overrun_q, noise_err_q, framing_fault_q,
                                     parity_fault_q};
        `ASCS_ADDR_DAT: prdata_q <= {24'h000000, rdata_q};
        `ASCS_ADDR_BAUD: prdata_q <= {16'h0000, baud_q};
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  // Control writes; transmitter and receiver enables only change while module is on
  always_comb begin
    trc_wr = pwdata[7:0];
    if (!module_on) begin
      trc_wr[`ASCS_TRC_TX_ON] = tx_on;
      trc_wr[`ASCS_TRC_RX_ON] = rx_on;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lfc_q <= `ASCS_LFC_RST;
      baud_q <= `ASCS_BAUD_RST;
      tx_ninth_bit_q <= 1'b0;
      err_en_q <= `ASCS_NEC_RST;
    end else if (wr) begin
      if (paddr == `ASCS_ADDR_LFC) begin
        lfc_q <= pwdata[7:0] & `ASCS_LFC_MASK;
      end
      if (paddr == `ASCS_ADDR_NEC) begin
        tx_ninth_bit_q <= pwdata[`ASCS_NEC_TX_NINTH];
        err_en_q <= pwdata[3:0];
      end
      if (paddr == `ASCS_ADDR_BAUD) begin
        baud_q <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trc_q <= `ASCS_TRC_RST;
    end else if (wr && paddr == `ASCS_ADDR_TRC) begin
      trc_q <= trc_wr;
    end else if (addr_wake | (quiet_event & rx_standby & ~wake)) begin
      trc_q[1] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (wr && paddr == `ASCS_ADDR_DAT) begin
      tdata_q <= pwdata[7:0];
    end
  end

  // Oversampling tick, 16 per bit
  always_ff @(posedge clk) begin
    if (rst || !module_on || div_q == 16'h0000) begin
      div_q <= baud_q;
    end else begin
      div_q <= div_q - 16'h0001;
    end
  end
  assign tick = module_on & (div_q == 16'h0000);

  // Transmitter
  assign tx_done = tx_buffer_empty_q & (tx_st_q == ASCS_TX_IDLE) &
                   ~pre_pend_q & ~brk_pend_q & ~(break_send & tx_on);
  assign tx_bit_end = tick & (tx_ph_q == `ASCS_PHASE_LAST);
  assign tx_load = (tx_st_q == ASCS_TX_IDLE) & module_on & tx_on & ~brk_pend_q &
                   ~break_send & ~pre_pend_q & ~tx_buffer_empty_q;

  always_comb begin
    frame = {3'b111, tdata_q, 1'b0};
    if (nine) begin
      frame[9] = parity_on ? ascs_xor({1'b0, tdata_q}, 1'b1) ^ odd_parity_sel
                           : tx_ninth_bit_q;
    end else if (parity_on) begin
      frame[8] = ascs_xor({2'b00, tdata_q[6:0]}, 1'b0) ^ odd_parity_sel;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
    end else if (!module_on) begin
      pre_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
    end else begin
      if (wr && paddr == `ASCS_ADDR_TRC && trc_wr[3] && !tx_on) begin
        pre_pend_q <= 1'b1;
      end else if (tx_st_q == ASCS_TX_IDLE && tx_on && !brk_pend_q && !break_send) begin
        pre_pend_q <= 1'b0;
      end
      if (wr && paddr == `ASCS_ADDR_TRC && pwdata[0] && !break_send) begin
        brk_pend_q <= 1'b1;
      end else if (tx_st_q == ASCS_TX_IDLE && tx_on) begin
        brk_pend_q <= 1'b0;
        if (brk_pend_q | break_send) begin
          pre_pend_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !module_on) begin
      tx_st_q <= ASCS_TX_IDLE;
      tx_sh_q <= 12'hFFF;
      tx_cnt_q <= 4'h0;
      tx_ph_q <= 4'h0;
    end else begin
      if (tick) begin
        tx_ph_q <= tx_ph_q + 4'h1;
      end
      unique case (tx_st_q)
        ASCS_TX_IDLE: begin
          tx_ph_q <= 4'h0;
          tx_cnt_q <= len;
          if (tx_on && (brk_pend_q || break_send)) begin
            tx_sh_q <= 12'h000;
            tx_st_q <= ASCS_TX_BRK;
          end else if (tx_on && pre_pend_q) begin
            tx_sh_q <= 12'hFFF;
            tx_st_q <= ASCS_TX_PRE;
          end else if (tx_load) begin
            tx_sh_q <= frame;
            tx_st_q <= ASCS_TX_DATA;
          end
        end
        ASCS_TX_PRE, ASCS_TX_DATA, ASCS_TX_BRK: begin
          if (tx_bit_end) begin
            tx_sh_q <= {1'b1, tx_sh_q[11:1]};
            tx_cnt_q <= tx_cnt_q - 4'h1;
            if (tx_cnt_q == 4'h1) begin
              if (tx_st_q == ASCS_TX_BRK && break_send && tx_on) begin
                tx_sh_q <= 12'h000;
                tx_cnt_q <= len;
              end else if (tx_st_q == ASCS_TX_BRK) begin
                tx_sh_q <= 12'hFFF;
                tx_cnt_q <= 4'h1;
                tx_st_q <= ASCS_TX_DATA;
              end else begin
                tx_st_q <= ASCS_TX_IDLE;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txd_q <= 1'b1;
    end else begin
      txd_q <= (tx_st_q == ASCS_TX_IDLE) ? 1'b1 : tx_sh_q[0];
    end
  end
  assign txd = txd_q;

  // Transmit empty flag and its read-then-write clearing
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_buffer_empty_q <= 1'b1;
      tx_arm_q <= 1'b0;
    end else begin
      if (rd && paddr == `ASCS_ADDR_FLG) begin
        tx_arm_q <= prdata_q[7];
      end else if (wr && paddr == `ASCS_ADDR_DAT) begin
        tx_arm_q <= 1'b0;
      end
      if (!module_on || tx_load) begin
        tx_buffer_empty_q <= 1'b1;
      end else if (wr && paddr == `ASCS_ADDR_DAT && tx_arm_q) begin
        tx_buffer_empty_q <= 1'b0;
      end
    end
  end

  // Receiver
  assign rx_sample = tick & (rx_ph_q == `ASCS_PHASE_S3);
  assign rx_bit = (s1_q & s2_q) | (s1_q & rxd) | (s2_q & rxd);
  assign noise_now = ~((s1_q == s2_q) & (s2_q == rxd));
  assign stop_now = rx_sample & (rx_st_q == ASCS_RX_DATA) & (rx_cnt_q == nbits);
  assign rx_msbv = rx_sh_q[8:0];
  assign addr_wake = stop_now & rx_standby & wake &
                     (nine ? rx_msbv[8] : rx_msbv[7]);
  assign accept = stop_now & (~rx_standby | addr_wake);
  assign quiet_event = rx_sample & rx_bit & (ones_q == len - 4'h1) &
                       ((rx_st_q == ASCS_RX_IDLE) | ~quiet_count_after_stop);

  always_ff @(posedge clk) begin
    if (rst || !module_on || !rx_on) begin
      rx_st_q <= ASCS_RX_IDLE;
      rx_ph_q <= 4'h0;
      rx_cnt_q <= 4'h0;
      rx_noise_q <= 1'b0;
      ones_q <= 4'h0;
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      if (tick) begin
        rx_ph_q <= rx_ph_q + 4'h1;
        if (rx_ph_q == `ASCS_PHASE_S1) begin
          s1_q <= rxd;
        end
        if (rx_ph_q == `ASCS_PHASE_S2) begin
          s2_q <= rxd;
        end
      end
      if (rx_sample) begin
        if (!rx_bit) begin
          ones_q <= 4'h0;
        end else if ((rx_st_q == ASCS_RX_IDLE || !quiet_count_after_stop) && ones_q != len) begin
          ones_q <= ones_q + 4'h1;
        end
      end
      unique case (rx_st_q)
        ASCS_RX_IDLE: begin
          if (tick && !rxd) begin
            rx_st_q <= ASCS_RX_START;
            rx_ph_q <= 4'h0;
          end
        end
        ASCS_RX_START: begin
          if (rx_sample) begin
            rx_st_q <= rx_bit ? ASCS_RX_IDLE : ASCS_RX_DATA;
            rx_cnt_q <= 4'h0;
            rx_noise_q <= noise_now;
            if (quiet_count_after_stop) begin
              ones_q <= 4'h0;
            end
          end
        end
        ASCS_RX_DATA: begin
          if (rx_sample) begin
            rx_sh_q[rx_cnt_q] <= rx_bit;
            rx_cnt_q <= rx_cnt_q + 4'h1;
            rx_noise_q <= rx_noise_q | noise_now;
            if (rx_cnt_q == nbits) begin
              rx_st_q <= ASCS_RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Received data and ninth bit, not touched by reset
  always_ff @(posedge clk) begin
    if (accept && !rx_buffer_full_q) begin
      rdata_q <= rx_sh_q[7:0];
      rx_ninth_bit_q <= nine ? rx_sh_q[8] : rx_sh_q[7];
    end
  end

  // Receive flags; a new event wins over the clearing data read
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_arm_q <= 6'h00;
      {rx_buffer_full_q, idle_q, overrun_q} <= 3'b000;
      {noise_err_q, framing_fault_q, parity_fault_q} <= 3'b000;
      idle_armed_q <= 1'b0;
    end else begin
      if (rd && paddr == `ASCS_ADDR_FLG) begin
        rx_arm_q <= prdata_q[5:0];
      end else if (rd && paddr == `ASCS_ADDR_DAT) begin
        rx_arm_q <= 6'h00;
        if (rx_arm_q[5]) rx_buffer_full_q <= 1'b0;
        if (rx_arm_q[4]) idle_q <= 1'b0;
        if (rx_arm_q[3]) overrun_q <= 1'b0;
        if (rx_arm_q[2]) noise_err_q <= 1'b0;
        if (rx_arm_q[1]) framing_fault_q <= 1'b0;
        if (rx_arm_q[0]) parity_fault_q <= 1'b0;
      end
      if (accept) begin
        if (rx_buffer_full_q) begin
          overrun_q <= 1'b1;
        end else begin
          rx_buffer_full_q <= 1'b1;
          idle_armed_q <= 1'b1;
          if (rx_noise_q) noise_err_q <= 1'b1;
          if (!rx_bit) framing_fault_q <= 1'b1;
          if (parity_on && ascs_xor(rx_sh_q[8:0], nine) != odd_parity_sel) begin
            parity_fault_q <= 1'b1;
          end
        end
      end
      if (quiet_event && idle_armed_q && !rx_standby) begin
        idle_q <= 1'b1;
        idle_armed_q <= 1'b0;
      end
    end
  end

  // Interrupt requests
  assign tx_irq = module_on & ((tx_buffer_empty_q & tx_empty_irq_en) |
                               (tx_done & tx_done_irq_en));
  assign rx_irq = ~rx_standby & ((rx_buffer_full_q & rx_full_irq_en) |
                                 (idle_q & quiet_irq_en));
  assign err_irq = |({overrun_q, noise_err_q, framing_fault_q, parity_fault_q} &
                     err_en_q);

endmodule

/* File: ascs_monitor.sv */
// Purpose: Port checker for the serial control and status block
// Assumes: Offsets and bit positions from ascs_params.svh
// Notes: Shadows enable bits from APB writes to judge the outputs
`timescale 1ns/1ps
`include "ascs_params.svh"
module ascs_monitor (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic rxd, // Serial in
  input wire logic txd, // Serial out
  input wire logic tx_irq, // Tx request
  input wire logic rx_irq, // Rx request
  input wire logic err_irq // Error request
);
  logic acc, wr_dat, mod_q, txe_q;
  logic [7:0] trc_q;
  logic [3:0] nec_q;
  assign acc = psel && penable && pready;
  assign wr_dat = acc && pwrite && paddr == `ASCS_ADDR_DAT;
  always_ff @(posedge clk) begin
    if (rst) begin
      mod_q <= 1'b0;
    end else if (acc && pwrite && paddr == `ASCS_ADDR_LFC) begin
      mod_q <= pwdata[`ASCS_LFC_MODULE_ON];
    end
  end
  // Tx and rx enable bits ignored while the module is off
  always_ff @(posedge clk) begin
    if (rst) begin
      trc_q <= 8'h00;
    end else if (acc && pwrite && paddr == `ASCS_ADDR_TRC) begin
      trc_q <= {pwdata[7:4], mod_q ? pwdata[3:2] : trc_q[3:2], pwdata[1:0]};
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      nec_q <= 4'h0;
    end else if (acc && pwrite && paddr == `ASCS_ADDR_NEC) begin
      nec_q <= pwdata[3:0];
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      txe_q <= 1'b0;
    end else begin
      txe_q <= txe_q | (mod_q & trc_q[3]);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property ($fell(rst) |-> txd && !tx_irq && !rx_irq && !err_irq && prdata == 32'h0)
    else $error("outputs not quiet after reset");
  a_txirq_module_off: assert property (!mod_q |-> !tx_irq)
    else $error("tx request while module off");
  a_txirq_masked: assert property (trc_q[7:6] == 2'b00 |-> !tx_irq)
    else $error("tx request while masked");
  a_txirq_reenable: assert property ($rose(mod_q) && trc_q[7] |-> tx_irq)
    else $error("empty not set after module off");
  a_rxirq_masked: assert property (trc_q[5:4] == 2'b00 |-> !rx_irq)
    else $error("rx request while masked");
  a_errirq_masked: assert property (nec_q == 4'h0 |-> !err_irq)
    else $error("error request while masked");
  a_empty_clear: assert property (mod_q && trc_q[7:6] == 2'b10 && $stable(trc_q) && $stable(mod_q)
    && $fell(tx_irq) |-> $past(wr_dat))
    else $error("empty cleared without data write");
  a_ctrl_readback: assert property (acc && !pwrite && paddr == `ASCS_ADDR_TRC
    |-> prdata[7:4] == trc_q[7:4])
    else $error("interrupt enables read back wrong");
  a_idle_high: assert property (!txe_q |-> ##1 txd)
    else $error("line left idle level before enable");
endmodule
bind ascs_ctrl ascs_monitor i_ascs_monitor (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .tx_irq(tx_irq),
  .rx_irq(rx_irq), .err_irq(err_irq));

/* File: ascs_partner.sv */
// Purpose: Remote serial node on the line side
// Assumes: Idle-high line, LSB first, fixed bit time in clocks
// Notes: Captures nine bits after each start bit
`timescale 1ns/1ps
module ascs_partner #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk, // Clock
  input wire logic txd, // Line from the block
  output logic rxd // Line into the block
);
  logic [8:0] got;
  int got_cnt = 0;
  initial rxd = 1'b1;
  // Sample each bit in its middle
  always begin
    @(negedge txd);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      got[i] = txd;
    end
    got_cnt++;
  end
  task automatic send(input logic [8:0] d, input int n, input logic stp);
    rxd <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rxd <= d[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rxd <= stp;
    repeat (BIT_CLKS) @(posedge clk);
    rxd <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask
endmodule

/* File: testbench.sv */
// Purpose: Self-checking bench for the serial control and status block
// Assumes: Divisor 1 gives 32 clocks per bit
// Notes: Random data from a fixed-seed shift register
`timescale 1ns/1ps
`include "ascs_params.svh"
module testbench;
  localparam int BITC = 32;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, rxd, txd, tx_irq, rx_irq, err_irq;
  logic er, p;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] seed = 16'hCE60;
  logic [7:0] fmt [5] = '{8'h40, 8'h42, 8'h43, 8'h50, 8'h53};
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int t0, k, len;
  ascs_ctrl i_ascs_ctrl (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq),
    .err_irq(err_irq));
  ascs_partner #(.BIT_CLKS(BITC)) i_ascs_partner (.clk(clk), .txd(txd), .rxd(rxd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [8:0] exp_frame(input logic [7:0] f, input logic [7:0] d,
                                           input logic t8);
    if (!f[4] && !f[1]) return {1'b1, d};
    if (!f[4]) return {1'b1, ^d[6:0] ^ f[0], d[6:0]};
    if (!f[1]) return {t8, d};
    return {^d ^ f[0], d};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`ASCS_ADDR_TRC);
    chk("ctrl", 32'h0, r);
    rd(`ASCS_ADDR_FLG);
    chk("flags", 32'h000000C0, r);
    rd(`ASCS_ADDR_NEC);
    chk("ninth ctrl", 32'h0, 32'(r[6:0]));
    rd(8'h1C);
    chk("unmapped", 32'h1, {r[30:0], er});
    wr(`ASCS_ADDR_TRC, 32'h0C);
    rd(`ASCS_ADDR_TRC);
    chk("gated enables", 32'h0, r);
    for (int i = 0; i < 4; i++) begin
      wr(`ASCS_ADDR_TRC, 32'(i << 6));
      chk("tx_irq off", 32'h0, 32'(tx_irq));
      wr(`ASCS_ADDR_LFC, 32'h40);
      chk("tx_irq", 32'(i != 0), 32'(tx_irq));
      wr(`ASCS_ADDR_LFC, 32'h0);
    end
    wr(`ASCS_ADDR_BAUD, 32'h1);
    for (int m = 0; m < 5; m++) begin
      seed = lfsr(seed);
      len = fmt[m][4] ? 11 : 10;
      wr(`ASCS_ADDR_TRC, 32'h80);
      repeat (2 * BITC) @(posedge clk);
      wr(`ASCS_ADDR_LFC, 32'(fmt[m]));
      wr(`ASCS_ADDR_NEC, 32'({seed[8], 6'h00}));
      wr(`ASCS_ADDR_TRC, 32'h88);
      t0 = cyc;
      k = i_ascs_partner.got_cnt;
      rd(`ASCS_ADDR_FLG);
      wr(`ASCS_ADDR_DAT, 32'(seed[7:0]));
      while (txd !== 1'b0) @(posedge clk);
      chk("preamble", 32'h1, 32'(cyc - t0 >= len * BITC - 4 && cyc - t0 < (len + 2) * BITC));
      while (i_ascs_partner.got_cnt == k) @(posedge clk);
      chk("frame", 32'(exp_frame(fmt[m], seed[7:0], seed[8])), 32'(i_ascs_partner.got));
      rd(`ASCS_ADDR_FLG);
      chk("empty", 32'h1, 32'(r[7]));
    end
    // Break toggle: one break character, then a high bit
    k = i_ascs_partner.got_cnt;
    wr(`ASCS_ADDR_TRC, 32'h89);
    wr(`ASCS_ADDR_TRC, 32'h88);
    while (i_ascs_partner.got_cnt == k) @(posedge clk);
    chk("break", 32'h0, 32'(i_ascs_partner.got));
    wr(`ASCS_ADDR_TRC, 32'h0);
    repeat (3 * BITC) @(posedge clk);
    chk("idle line", 32'h1, 32'(txd));
    wr(`ASCS_ADDR_LFC, 32'h46);
    wr(`ASCS_ADDR_NEC, 32'h0F);
    wr(`ASCS_ADDR_TRC, 32'h20);
    i_ascs_partner.send(9'h055, 8, 1'b1);
    chk("rx off", 32'h0, 32'(rx_irq));
    wr(`ASCS_ADDR_TRC, 32'h24);
    for (int j = 0; j < 3; j++) begin
      seed = lfsr(seed);
      p = ^seed[6:0] ^ (j == 1);
      i_ascs_partner.send({1'b0, p, seed[6:0]}, 8, j != 2);
      chk("rx_irq", 32'h1, 32'(rx_irq));
      chk("err_irq", 32'(j != 0), 32'(err_irq));
      rd(`ASCS_ADDR_FLG);
      chk("rx flags", 32'({4'b1000, j == 2, j == 1}), 32'(r[5:0] & 6'h2F));
      rd(`ASCS_ADDR_DAT);
      chk("rx data", 32'({p, seed[6:0]}), r);
      rd(`ASCS_ADDR_NEC);
      chk("rx ninth", 32'(p), 32'(r[7]));
      chk("irq clear", 32'h0, 32'({rx_irq, err_irq}));
    end
    // Standby with idle wakeup: character dropped, quiet line wakes
    wr(`ASCS_ADDR_TRC, 32'h26);
    i_ascs_partner.send({1'b0, seed[7:0]}, 8, 1'b1);
    chk("standby irq", 32'h0, 32'(rx_irq));
    repeat (12 * BITC) @(posedge clk);
    rd(`ASCS_ADDR_TRC);
    chk("wake idle", 32'h24, r);
    rd(`ASCS_ADDR_FLG);
    chk("standby flags", 32'h0, 32'(r[5:4]));
    wrap_up();
  end
endmodule
